// *** pseq_indirect.sv ***
`timescale 1ns/1ps
`include "pseq_regs.svh"
module pseq_indirect
    import pseq_pkg::*;
(
    input  wire logic          banked,
    input  wire logic [6:0]    fsrValue,
    input  wire logic [6:0]    directAddr,
    input  wire logic          fileWrite,
    output logic      [6:0]    effAddr,
    output logic               effWrite,
    output logic               readZero,
    output logic      [6:0]    fsrView
);
    logic isIndirect;
    logic selfRef;
    always_comb
    begin
        // unbanked pointer reads ones in the bank field
        fsrView = banked ? fsrValue : {2'b11, fsrValue[4:0]}; // [R20]
        isIndirect = (directAddr[4:0] == `PSEQ_INDIRECT_DATA_PORT_ADDR); // [R15]
        selfRef = isIndirect && (fsrValue[4:0] == `PSEQ_INDIRECT_DATA_PORT_ADDR);
        if (isIndirect)
            effAddr = {banked ? fsrValue[6:5] : 2'b00,
                       fsrValue[4:0]}; // [R15] [R19] [R20]
        else
            effAddr = directAddr;
        readZero = selfRef; // [R16]
        effWrite = fileWrite && !selfRef; // [R17]
    end
endmodule : pseq_indirect

// *** pseq_pkg.sv ***
package pseq_pkg;
    typedef enum logic [1:0]
    {
        PSEQ_VAR_SMALL = 2'h0,
        PSEQ_VAR_MID   = 2'h1,
        PSEQ_VAR_LARGE = 2'h3
    } pseq_variant_e;
    typedef enum logic [2:0]
    {
        PSEQ_OP_STEP   = 3'h0,
        PSEQ_OP_JUMP   = 3'h1,
        PSEQ_OP_CALL   = 3'h3,
        PSEQ_OP_RET    = 3'h2,
        PSEQ_OP_PCLWR  = 3'h6
    } pseq_op_e;
    typedef logic [10:0] pseq_pc_t;
endpackage : pseq_pkg

// *** pseq_regs.svh ***
`ifndef PSEQ_REGS_SVH
`define PSEQ_REGS_SVH
`define PSEQ_PC_W        11
`define PSEQ_PC_RESET    11'h7ff
`define PSEQ_PAGE_RESET  2'h0
`define PSEQ_PAGE_LSB    5
`define PSEQ_PAGE_MSB    6
`define PSEQ_PCL_ADDR    5'h02
`define PSEQ_INDIRECT_DATA_PORT_ADDR   5'h00
`define PSEQ_FSR_ADDR    5'h04
`define PSEQ_FSR_RESET   7'h00
`endif

// *** pseq_sequencer.sv ***
// What this block does
// R1: pc steps by one each cycle unless an instruction loads it
// R2: jump loads pc bits 8:0 from the instruction immediate
// R3: low pc latch reads and writes pc bits 7:0
// R4: on large variants page bits supply pc bits 9 and 10 on loads
// R5: call or latch write loads bits 7:0, forces bit 8 low
// R6: move, add and bit-set to the latch all use call-style load
// R7: stepping past a page end enters next page, page bits unchanged
// R8: loads go to preselected page; software updates page bits itself
// R9: reset sets pc to all ones, the reset vector
// R10: reset clears page bits, preselecting page 0
// R11: return stack has two levels as wide as the pc
// R12: call copies level 1 to level 2, pushes pc plus one
// R13: return loads pc from level 1, copies level 2 to level 1
// R14: return loads the working register with the instruction literal
// R15: indirect port access goes to register pointed by the pointer
// R16: pointer zero makes an indirect read return zero
// R17: indirect write to the port itself stores nothing
// R18: page field 00..11 selects page 0..3
// R19: pointer low five bits select addresses 00h to 1fh
// R20: banked pointer bits 6:5 select bank; unbanked read as ones
`timescale 1ns/1ps
`include "pseq_regs.svh"
module pseq_sequencer
    import pseq_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          ce,
    input  wire pseq_variant_e variant,
    input  wire pseq_op_e      op,
    input  wire logic [8:0]    immediate,
    input  wire logic [7:0]    pclWriteData,
    input  wire logic          statusWrite,
    input  wire logic [7:0]    statusWriteData,
    input  wire logic          fsrWrite,
    input  wire logic [6:0]    fsrWriteData,
    input  wire logic [6:0]    directAddr,
    input  wire logic          fileWrite,
    output logic      [10:0]   progAddr,
    output logic      [7:0]    pcLowLatch,
    output logic      [1:0]    pagePreselect,
    output logic               workLoad,
    output logic      [7:0]    workData,
    output logic      [6:0]    filePointer,
    output logic      [6:0]    fileAddr,
    output logic               fileWriteEn,
    output logic               fileReadZero,
    output logic      [10:0]   stackTop,
    output logic      [10:0]   stackBottom
);
    pseq_pc_t   pc_q;
    pseq_pc_t   pc_d;
    logic [1:0] page_q;
    logic [1:0] page_d;
    logic [6:0] fsr_q;
    logic [6:0] fsr_d;
    logic       wload_q;
    logic       wload_d;
    logic [7:0] wdata_q;
    logic [7:0] wdata_d;
    pseq_pc_t   pcMask;
    pseq_pc_t   pcInc;
    pseq_pc_t   pageBits;
    pseq_pc_t   lvl1;
    pseq_pc_t   lvl2;
    pseq_pc_t   lvl1In;
    logic       lvl1Load;
    logic       lvl2Load;

    always_comb
    begin
        // pc width by variant: 9, 10 or 11 bits
        case (variant) // [R11]
            PSEQ_VAR_SMALL: pcMask = 11'h1ff;
            PSEQ_VAR_MID:   pcMask = 11'h3ff;
            default:        pcMask = 11'h7ff;
        endcase
        pcInc = (pc_q + 11'h001) & pcMask; // [R1] [R7]
        // page field maps to pc 10:9, masked to the pc width of the variant // [R18]
        pageBits = {page_q, 9'h000} & pcMask; // [R4] [R8]
    end

    // pc, page and working-register sequencing
    always_comb
    begin
        pc_d = pcInc; // [R1] [R7]
        page_d = page_q; // [R7]
        wload_d = 1'b0;
        wdata_d = wdata_q;
        lvl1Load = 1'b0;
        lvl2Load = 1'b0;
        lvl1In = lvl1;
        case (op)
            PSEQ_OP_JUMP:
                pc_d = pageBits | {2'b00, immediate}; // [R2] [R4]
            PSEQ_OP_CALL:
            begin
                pc_d = pageBits | {3'b000, immediate[7:0]}; // [R5]
                lvl2Load = 1'b1; // [R12]
                lvl1Load = 1'b1;
                lvl1In = pcInc; // [R12]
            end
            PSEQ_OP_RET:
            begin
                pc_d = lvl1 & pcMask; // [R13]
                lvl1Load = 1'b1;
                lvl1In = lvl2; // [R13]
                wload_d = 1'b1; // [R14]
                wdata_d = immediate[7:0]; // [R14]
            end
            PSEQ_OP_PCLWR:
                pc_d = pageBits | {3'b000, pclWriteData}; // [R3] [R5] [R6]
            default:
                pc_d = pcInc;
        endcase
        if (statusWrite && variant != PSEQ_VAR_SMALL)
            page_d = statusWriteData[`PSEQ_PAGE_MSB:`PSEQ_PAGE_LSB]; // [R8]
        else if (statusWrite)
            page_d = `PSEQ_PAGE_RESET;
        fsr_d = fsrWrite ? fsrWriteData : fsr_q;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pc_q <= `PSEQ_PC_RESET; // [R9]
            page_q <= `PSEQ_PAGE_RESET; // [R10]
            fsr_q <= `PSEQ_FSR_RESET;
            wload_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else if (ce)
        begin
            pc_q <= pc_d;
            page_q <= page_d;
            fsr_q <= fsr_d;
            wload_q <= wload_d;
            wdata_q <= wdata_d;
        end
    end

    pseq_stack_level u_level1
    (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .load      (lvl1Load),
        .loadValue (lvl1In),
        .value     (lvl1)
    );

    pseq_stack_level u_level2
    (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .load      (lvl2Load),
        .loadValue (lvl1),
        .value     (lvl2)
    );

    pseq_indirect u_indirect
    (
        .banked     (variant == PSEQ_VAR_LARGE),
        .fsrValue   (fsr_q),
        .directAddr (directAddr),
        .fileWrite  (fileWrite),
        .effAddr    (fileAddr),
        .effWrite   (fileWriteEn),
        .readZero   (fileReadZero),
        .fsrView    (filePointer)
    );

    assign progAddr = pc_q & pcMask; // [R9]
    assign pcLowLatch = pc_q[7:0]; // [R3]
    assign pagePreselect = page_q;
    assign workLoad = wload_q;
    assign workData = wdata_q;
    assign stackTop = lvl1;
    assign stackBottom = lvl2;

    sequence s_call;
        op == PSEQ_OP_CALL && ce;
    endsequence
    sequence s_ret;
        op == PSEQ_OP_RET && ce;
    endsequence
    sequence s_load;
        ce && (op == PSEQ_OP_JUMP || op == PSEQ_OP_CALL
               || op == PSEQ_OP_PCLWR);
    endsequence

    AST_STEP: assert property (@(posedge mclk) disable iff (reset) // [R1]
        ce && op == PSEQ_OP_STEP |=> pc_q == $past(pcInc))
        else $error("pc did not step");

    AST_FREEZE: assert property (@(posedge mclk) // [R1]
        disable iff (reset)
        !ce |=> pc_q == $past(pc_q) && page_q == $past(page_q)
        && lvl1 == $past(lvl1) && lvl2 == $past(lvl2)
        && fsr_q == $past(fsr_q) && workLoad == $past(workLoad))
        else $error("state moved while frozen");

    AST_JUMP: assert property (@(posedge mclk) disable iff (reset) // [R2]
        ce && op == PSEQ_OP_JUMP |=> pc_q[8:0] == $past(immediate))
        else $error("jump low bits wrong");

    AST_CALL_B8: assert property (@(posedge mclk) disable iff (reset) // [R5]
        ce && (op == PSEQ_OP_CALL || op == PSEQ_OP_PCLWR) |=> !pc_q[8])
        else $error("bit 8 not cleared");

    AST_CALL_LOW: assert property (@(posedge mclk) // [R5]
        disable iff (reset)
        s_call |=> pc_q[7:0] == $past(immediate[7:0]))
        else $error("call low bits wrong");

    AST_PAGE: assert property (@(posedge mclk) disable iff (reset) // [R4]
        ce && op == PSEQ_OP_JUMP && variant == PSEQ_VAR_LARGE
        |=> pc_q[10:9] == $past(page_q))
        else $error("page bits not applied");

    AST_LOAD_PAGE: assert property (@(posedge mclk) // [R4] [R8]
        disable iff (reset)
        s_load && variant == PSEQ_VAR_LARGE
        |=> pc_q[10:9] == $past(page_q))
        else $error("load ignored page bits");

    AST_PCLWR: assert property (@(posedge mclk) disable iff (reset) // [R3]
        ce && op == PSEQ_OP_PCLWR |=> pcLowLatch == $past(pclWriteData))
        else $error("latch write lost");

    AST_PAGE_KEEP: assert property (@(posedge mclk) // [R7]
        disable iff (reset)
        ce && !statusWrite |=> page_q == $past(page_q))
        else $error("page bits changed without write");

    AST_PAGE_WR: assert property (@(posedge mclk) // [R8] [R18]
        disable iff (reset)
        ce && statusWrite && variant != PSEQ_VAR_SMALL
        |=> page_q == $past(statusWriteData[`PSEQ_PAGE_MSB:`PSEQ_PAGE_LSB]))
        else $error("page write lost");

    AST_PAGE_SMALL: assert property (@(posedge mclk) // [R4]
        disable iff (reset)
        ce && statusWrite && variant == PSEQ_VAR_SMALL
        |=> page_q == `PSEQ_PAGE_RESET)
        else $error("page bits stored on small variant");

    AST_PUSH: assert property (@(posedge mclk) disable iff (reset) // [R12]
        s_call |=> lvl2 == $past(lvl1) && lvl1 == $past(pcInc))
        else $error("push wrong");

    AST_POP: assert property (@(posedge mclk) disable iff (reset) // [R13]
        s_ret |=> pc_q == ($past(lvl1) & pcMask) && lvl1 == $past(lvl2)
        && lvl2 == $past(lvl2))
        else $error("pop wrong");

    AST_STACK_HOLD: assert property (@(posedge mclk) // [R11]
        disable iff (reset)
        ce && !(op == PSEQ_OP_CALL || op == PSEQ_OP_RET)
        |=> lvl1 == $past(lvl1) && lvl2 == $past(lvl2))
        else $error("stack moved without call or return");

    AST_RETW: assert property (@(posedge mclk) disable iff (reset) // [R14]
        s_ret |=> workLoad && workData == $past(immediate[7:0]))
        else $error("literal not loaded");

    AST_WLOAD_LOW: assert property (@(posedge mclk) // [R14]
        disable iff (reset)
        ce && op != PSEQ_OP_RET |=> !workLoad)
        else $error("working load without return");

    AST_RESET: assert property (@(posedge mclk) // [R9]
        $past(reset) |-> pc_q == `PSEQ_PC_RESET && page_q == 2'h0)
        else $error("reset values wrong");

    AST_RESET_STACK: assert property (@(posedge mclk) // [R11]
        $past(reset) |-> lvl1 == 11'h000 && lvl2 == 11'h000
        && !workLoad && fsr_q == `PSEQ_FSR_RESET)
        else $error("stack reset values wrong");

    AST_IND_BANKED: assert property (@(posedge mclk) // [R15] [R20]
        disable iff (reset)
        directAddr[4:0] == `PSEQ_INDIRECT_DATA_PORT_ADDR && variant == PSEQ_VAR_LARGE
        |-> fileAddr == fsr_q)
        else $error("banked indirect address wrong");

    AST_IND_FLAT: assert property (@(posedge mclk) // [R19] [R20]
        disable iff (reset)
        directAddr[4:0] == `PSEQ_INDIRECT_DATA_PORT_ADDR && variant != PSEQ_VAR_LARGE
        |-> fileAddr == {2'b00, fsr_q[4:0]})
        else $error("unbanked indirect address wrong");

    AST_DIRECT: assert property (@(posedge mclk) // [R15]
        disable iff (reset)
        directAddr[4:0] != `PSEQ_INDIRECT_DATA_PORT_ADDR |-> fileAddr == directAddr
        && fileWriteEn == fileWrite && !fileReadZero)
        else $error("direct access altered");

    AST_PTR_FLAT: assert property (@(posedge mclk) // [R20]
        disable iff (reset)
        variant != PSEQ_VAR_LARGE |-> filePointer == {2'b11, fsr_q[4:0]})
        else $error("unbanked pointer view wrong");

    AST_SELF_ZERO: assert property (@(posedge mclk) // [R16]
        disable iff (reset)
        directAddr[4:0] == `PSEQ_INDIRECT_DATA_PORT_ADDR && fsr_q[4:0] == 5'h00
        |-> fileReadZero)
        else $error("self read not zero");

    AST_SELF: assert property (@(posedge mclk) disable iff (reset) // [R17]
        fileReadZero |-> !fileWriteEn)
        else $error("self write stored");

    AST_FSR_WR: assert property (@(posedge mclk) // [R15]
        disable iff (reset)
        ce && fsrWrite |=> fsr_q == $past(fsrWriteData))
        else $error("pointer write lost");
endmodule : pseq_sequencer

// *** pseq_stack_level.sv ***
`timescale 1ns/1ps
module pseq_stack_level
    import pseq_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     reset,
    input  wire logic     ce,
    input  wire logic     load,
    input  wire pseq_pc_t loadValue,
    output pseq_pc_t      value
);
    pseq_pc_t level_q;
    pseq_pc_t level_d;
    always_comb
    begin
        level_d = level_q;
        if (load)
            level_d = loadValue;
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            level_q <= '0;
        else if (ce)
            level_q <= level_d;
    end
    assign value = level_q;
endmodule : pseq_stack_level

// *** test_pseq_sequencer.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
    begin \
        n_compared++; \
        if ((ac) !== (ex)) \
        begin \
            fail_count++; \
            $display("Error %s expected %h seen %h", nm, ex, ac); \
        end \
    end
module test_pseq_sequencer
    import pseq_pkg::*;
;
    logic          mclk;
    logic          reset;
    logic          ce;
    pseq_variant_e variant;
    pseq_op_e      op;
    logic [8:0]    immediate;
    logic [7:0]    pclWriteData;
    logic          statusWrite;
    logic [7:0]    statusWriteData;
    logic          fsrWrite;
    logic [6:0]    fsrWriteData;
    logic [6:0]    directAddr;
    logic          fileWrite;
    logic [10:0]   progAddr;
    logic [7:0]    pcLowLatch;
    logic [1:0]    pagePreselect;
    logic          workLoad;
    logic [7:0]    workData;
    logic [6:0]    filePointer;
    logic [6:0]    fileAddr;
    logic          fileWriteEn;
    logic          fileReadZero;
    logic [10:0]   stackTop;
    logic [10:0]   stackBottom;
    int            fail_count = 0;
    int            n_compared = 0;
    int            cycles     = 0;

    pseq_sequencer dut (.mclk(mclk), .reset(reset), .ce(ce),
        .variant(variant), .op(op), .immediate(immediate),
        .pclWriteData(pclWriteData), .statusWrite(statusWrite),
        .statusWriteData(statusWriteData), .fsrWrite(fsrWrite),
        .fsrWriteData(fsrWriteData), .directAddr(directAddr),
        .fileWrite(fileWrite), .progAddr(progAddr),
        .pcLowLatch(pcLowLatch), .pagePreselect(pagePreselect),
        .workLoad(workLoad), .workData(workData),
        .filePointer(filePointer), .fileAddr(fileAddr),
        .fileWriteEn(fileWriteEn), .fileReadZero(fileReadZero),
        .stackTop(stackTop), .stackBottom(stackBottom));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // one instruction cycle, then op, status write and pointer write return to idle
    task automatic doOp(input pseq_op_e o, input logic [8:0] imm);
        op = o;
        immediate = imm;
        pclWriteData = imm[7:0];
        @(posedge mclk);
        #1;
        op = PSEQ_OP_STEP;
        statusWrite = 1'b0;
        fsrWrite = 1'b0;
    endtask : doOp

    task automatic doReset(input pseq_variant_e v);
        reset = 1'b1;
        variant = v;
        repeat (16) @(posedge mclk);
        #1;
        reset = 1'b0;
    endtask : doReset

    task automatic tReset();
        `CHK("progAddr", 11'h7ff, progAddr)
        `CHK("page", 2'h0, pagePreselect)
        ce = 1'b0;
        doOp(PSEQ_OP_JUMP, 9'h011);
        `CHK("frozen", 11'h7ff, progAddr)
        ce = 1'b1;
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("stepped", 11'h000, progAddr)
    endtask : tReset

    task automatic tPage();
        doOp(PSEQ_OP_JUMP, 9'h1ff);
        `CHK("jump", 11'h1ff, progAddr)
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("cross", 11'h200, progAddr)
        `CHK("pageKept", 2'h0, pagePreselect)
        doOp(PSEQ_OP_JUMP, 9'h034);
        `CHK("backPage0", 11'h034, progAddr)
        statusWrite = 1'b1;
        statusWriteData = 8'h60;
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("page3", 2'h3, pagePreselect)
        doOp(PSEQ_OP_JUMP, 9'h155);
        `CHK("paged", 11'h755, progAddr)
        `CHK("pcLow", 8'h55, pcLowLatch)
    endtask : tPage

    task automatic tStack();
        doOp(PSEQ_OP_CALL, 9'h188);
        `CHK("call", 11'h688, progAddr)
        `CHK("top1", 11'h756, stackTop)
        doOp(PSEQ_OP_CALL, 9'h010);
        `CHK("top2", 11'h689, stackTop)
        `CHK("bottom2", 11'h756, stackBottom)
        doOp(PSEQ_OP_RET, 9'h05a);
        `CHK("ret1", 11'h689, progAddr)
        `CHK("wLoad", 1'b1, workLoad)
        `CHK("wData", 8'h5a, workData)
        `CHK("popTop", 11'h756, stackTop)
        doOp(PSEQ_OP_RET, 9'h000);
        doOp(PSEQ_OP_RET, 9'h000);
        `CHK("ret3", 11'h756, progAddr)
        doOp(PSEQ_OP_PCLWR, 9'h13c);
        `CHK("pclWrite", 11'h63c, progAddr)
        `CHK("wLoadEnd", 1'b0, workLoad)
    endtask : tStack

    task automatic tIndirect();
        fsrWrite = 1'b1;
        fsrWriteData = 7'h45;
        doOp(PSEQ_OP_STEP, 9'h000);
        directAddr = 7'h00;
        fileWrite = 1'b1;
        #1;
        `CHK("indAddr", 7'h45, fileAddr)
        `CHK("indWr", 1'b1, fileWriteEn)
        @(posedge mclk);
        #1;
        fsrWrite = 1'b1;
        fsrWriteData = 7'h20;
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("selfZero", 1'b1, fileReadZero)
        `CHK("selfWr", 1'b0, fileWriteEn)
        fileWrite = 1'b0;
    endtask : tIndirect

    task automatic tSmall();
        doReset(PSEQ_VAR_SMALL);
        `CHK("smallPc", 11'h1ff, progAddr)
        fsrWrite = 1'b1;
        fsrWriteData = 7'h05;
        statusWrite = 1'b1;
        statusWriteData = 8'h60;
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("ptrView", 7'h65, filePointer)
        `CHK("smallInd", 7'h05, fileAddr)
        `CHK("smallPage", 2'h0, pagePreselect)
        doOp(PSEQ_OP_JUMP, 9'h1a5);
        `CHK("smallJump", 11'h1a5, progAddr)
    endtask : tSmall

    task automatic tMid();
        doReset(PSEQ_VAR_MID);
        `CHK("midPc", 11'h3ff, progAddr)
        statusWrite = 1'b1;
        statusWriteData = 8'h20;
        doOp(PSEQ_OP_STEP, 9'h000);
        `CHK("midPage", 2'h1, pagePreselect)
        doOp(PSEQ_OP_JUMP, 9'h0ab);
        `CHK("midJump", 11'h2ab, progAddr)
        doOp(PSEQ_OP_CALL, 9'h1c3);
        `CHK("midCall", 11'h2c3, progAddr)
        `CHK("midTop", 11'h2ac, stackTop)
    endtask : tMid

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        ce = 1'b1;
        op = PSEQ_OP_STEP;
        immediate = 9'h000;
        pclWriteData = 8'h00;
        statusWrite = 1'b0;
        statusWriteData = 8'h00;
        fsrWrite = 1'b0;
        fsrWriteData = 7'h00;
        directAddr = 7'h0a;
        fileWrite = 1'b0;
        doReset(PSEQ_VAR_LARGE);
        tReset();
        tPage();
        tStack();
        tIndirect();
        tSmall();
        tMid();
        end_of_test();
    end
endmodule : test_pseq_sequencer
